// file: src/eac_pkg.sv
// Package of constants for the EEPROM access controller
package eac_pkg;

    // ------------------------------------------------------------
    // Register map (I/O space offsets)
    // ------------------------------------------------------------
    localparam logic [5:0] CTRL_OFFSET = 6'h1c;
    localparam logic [5:0] DATA_OFFSET = 6'h1d;
    localparam logic [5:0] ADDR_OFFSET = 6'h1e;

    // ------------------------------------------------------------
    // Control register fields and reset values
    // ------------------------------------------------------------
    localparam int         READ_STROBE_POS = 0;
    localparam int         WRITE_STROBE_POS = 1;
    localparam int         WRITE_ARM_POS   = 2;
    localparam logic [7:0] CTRL_RESET      = 8'h00;
    localparam logic [7:0] ADDR_RESET      = 8'h00;
    localparam logic [7:0] DATA_RESET      = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_MHZ        = 200;
    localparam int          ARM_CYCLES     = 4;
    localparam int          STALL_CYCLES   = 2;
    localparam int          WRITE_TIME_US  = 2500;
    localparam int          WRITE_CYCLES   = WRITE_TIME_US * CLK_MHZ;

    typedef enum logic [1:0]
    {
        EAC_IDLE  = 2'b00,
        EAC_WRITE = 2'b01
    } eac_state_t;

endpackage : eac_pkg

// file: src/eac_top.sv
// EEPROM access controller: I/O registers, write protection, self timer
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Registers sit in CPU I/O register space, reached by plain I/O reads and writes.
// - Address register is a linear byte address 0 to 255 into the array.
// - Data register sources write data and receives read data.
// - Write strobe starts a write only when the arm bit is set.
// - Arm bit clears itself four cycles after software sets it.
// - Write strobe stays high for the self-timed write, then clears.
// - Setting the write strobe stalls the CPU for two cycles.
// - Read strobe fetches the addressed byte into data, then clears.
// - A read completes within one instruction; no polling needed.
// - Setting the read strobe stalls the CPU for two cycles.
// - Writing address or data during a write aborts it; result undefined.
// - Control bits 7 to 3 read as zero and ignore writes.
// - Array writes are blocked while low supply is detected.
module eac_top #(
    parameter int WRITE_CYCLES = eac_pkg::WRITE_CYCLES,
    parameter int DEPTH        = 256
)(
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_b_i,
    // CPU I/O register port
    input  wire logic [5:0] io_addr_i,
    input  wire logic       io_wr_i,
    input  wire logic       io_rd_i,
    input  wire logic [7:0] io_wdata_i,
    output logic      [7:0] io_rdata_o,
    output logic            cpu_stall_o,
    // Supply monitor (asynchronous pin)
    input  wire logic       low_supply_i,
    // Status
    output logic            write_busy_o
);

    // ------------------------------------------------------------
    // Decode and storage
    // ------------------------------------------------------------
    localparam int CW = $clog2(WRITE_CYCLES + 1);

    logic [7:0]          nv_byte_address;
    logic [7:0]          nv_byte_data;
    logic                write_arm_bit;
    logic                write_strobe_bit;
    logic [2:0]          arm_cnt;
    logic [CW-1:0]       wr_cnt;
    logic [1:0]          stall_cnt;
    logic [7:0]          array_mem [DEPTH];
    logic                low_meta;
    logic                low_sync;
    eac_pkg::eac_state_t state;

    logic wr_ctrl;
    logic wr_addr;
    logic wr_data;
    logic start_write;
    logic start_read;
    logic abort_write;

    function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
        hit = (a == off);
    endfunction : hit

    always_comb
    begin
        wr_ctrl     = io_wr_i && hit(io_addr_i, eac_pkg::CTRL_OFFSET);
        wr_addr     = io_wr_i && hit(io_addr_i, eac_pkg::ADDR_OFFSET);
        wr_data     = io_wr_i && hit(io_addr_i, eac_pkg::DATA_OFFSET);
        // Arm must already be set; writes during a write or low supply are dropped
        start_write = wr_ctrl && io_wdata_i[eac_pkg::WRITE_STROBE_POS] && write_arm_bit
                      && (state == eac_pkg::EAC_IDLE)
                      && !low_sync;
        start_read  = wr_ctrl && io_wdata_i[eac_pkg::READ_STROBE_POS]
                      && (state == eac_pkg::EAC_IDLE);
        abort_write = (wr_addr || wr_data) && (state == eac_pkg::EAC_WRITE);
    end

    // ------------------------------------------------------------
    // Supply detect synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            low_meta <= 1'b0;
            low_sync <= 1'b0;
        end
        else
        begin
            low_meta <= low_supply_i;
            low_sync <= low_meta;
        end
    end

    // ------------------------------------------------------------
    // Address register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            nv_byte_address <= eac_pkg::ADDR_RESET;
        else if (wr_addr)
            nv_byte_address <= io_wdata_i;
    end

    // ------------------------------------------------------------
    // Data register: CPU write or array read (read completes in one cycle)
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            nv_byte_data <= eac_pkg::DATA_RESET;
        else if (wr_data)
            nv_byte_data <= io_wdata_i;
        else if (start_read)
            nv_byte_data <= array_mem[nv_byte_address];
    end

    // ------------------------------------------------------------
    // Arm bit with four-cycle self clear
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            write_arm_bit <= 1'b0;
            arm_cnt       <= 3'h0;
        end
        else if (wr_ctrl && io_wdata_i[eac_pkg::WRITE_ARM_POS])
        begin
            write_arm_bit <= 1'b1;
            arm_cnt       <= 3'(eac_pkg::ARM_CYCLES - 1);
        end
        else if (write_arm_bit)
        begin
            if (arm_cnt == 3'h0)
                write_arm_bit <= 1'b0;
            else
                arm_cnt <= arm_cnt - 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Self-timed write
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state            <= eac_pkg::EAC_IDLE;
            write_strobe_bit <= 1'b0;
            wr_cnt           <= '0;
        end
        else
        begin
            case (state)
                eac_pkg::EAC_IDLE:
                begin
                    if (start_write)
                    begin
                        state            <= eac_pkg::EAC_WRITE;
                        write_strobe_bit <= 1'b1;
                        wr_cnt           <= CW'(WRITE_CYCLES - 1);
                    end
                end
                eac_pkg::EAC_WRITE:
                begin
                    // Abort leaves the cell contents undefined; we simply skip the commit
                    if (abort_write || wr_cnt == '0)
                    begin
                        state            <= eac_pkg::EAC_IDLE;
                        write_strobe_bit <= 1'b0;
                    end
                    else
                        wr_cnt <= wr_cnt - CW'(1);
                end
                default:
                begin
                    state            <= eac_pkg::EAC_IDLE;
                    write_strobe_bit <= 1'b0;
                end
            endcase
        end
    end

    // Commit at end of the timed write, unless aborted or supply is low in that last cycle
    always_ff @(posedge core_clk_i)
    begin
        if (state == eac_pkg::EAC_WRITE && wr_cnt == '0 && !abort_write && !low_sync)
            array_mem[nv_byte_address] <= nv_byte_data;
    end

    // ------------------------------------------------------------
    // CPU stall for two cycles on any strobe that starts a read or write
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            stall_cnt   <= 2'h0;
            cpu_stall_o <= 1'b0;
        end
        else if (start_write || start_read)
        begin
            stall_cnt   <= 2'(eac_pkg::STALL_CYCLES - 1);
            cpu_stall_o <= 1'b1;
        end
        else if (stall_cnt != 2'h0)
            stall_cnt <= stall_cnt - 2'h1;
        else
            cpu_stall_o <= 1'b0;
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            io_rdata_o   <= 8'h00;
            write_busy_o <= 1'b0;
        end
        else
        begin
            write_busy_o <= (state == eac_pkg::EAC_WRITE);
            if (!io_rd_i)
                io_rdata_o <= 8'h00;
            else if (hit(io_addr_i, eac_pkg::CTRL_OFFSET))
                io_rdata_o <= {5'h00, write_arm_bit, write_strobe_bit, 1'b0};
            else if (hit(io_addr_i, eac_pkg::ADDR_OFFSET))
                io_rdata_o <= nv_byte_address;
            else if (hit(io_addr_i, eac_pkg::DATA_OFFSET))
                io_rdata_o <= nv_byte_data;
            else
                io_rdata_o <= 8'h00;
        end
    end

endmodule : eac_top
`default_nettype wire

// file: tb/eac_props.sv
// Port checker of the EEPROM access controller
`timescale 1ns/1ps
`default_nettype none
module eac_props #(parameter int WRITE_CYCLES = 20)(
    // Clock, reset, CPU port, supply and status
    input wire logic       core_clk_i,
    input wire logic       rst_b_i,
    input wire logic [5:0] io_addr_i,
    input wire logic       io_wr_i,
    input wire logic       io_rd_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic [7:0] io_rdata_o,
    input wire logic       cpu_stall_o,
    input wire logic       low_supply_i,
    input wire logic       write_busy_o
);
    logic [2:0]  arm_cnt;
    logic [31:0] busy_cnt;
    wire         ctrl_wr = io_wr_i && io_addr_i == eac_pkg::CTRL_OFFSET;
    wire         go      = ctrl_wr && io_wdata_i[1] && !write_busy_o;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // Mirror of the arm window: a strobe is honoured on edges 1 to 4 after the arm write
    always_ff @(posedge core_clk_i or negedge rst_b_i)
        if (!rst_b_i) arm_cnt <= 3'h0;
        else if (ctrl_wr && io_wdata_i[2]) arm_cnt <= 3'h1;
        else if (arm_cnt == 3'h4) arm_cnt <= 3'h0;
        else if (arm_cnt != 3'h0) arm_cnt <= arm_cnt + 3'h1;
    always_ff @(posedge core_clk_i or negedge rst_b_i)
        if (!rst_b_i) busy_cnt <= 32'h0;
        else busy_cnt <= write_busy_o ? busy_cnt + 32'h1 : 32'h0;
    property p_idle; !io_rd_i |=> io_rdata_o == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data not zero when idle");
    property p_ctrl; io_rd_i && io_addr_i == eac_pkg::CTRL_OFFSET |=> io_rdata_o[7:3] == 5'h00 && !io_rdata_o[0];
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control read shows set bits");
    property p_rd_stall; ctrl_wr && io_wdata_i == 8'h01 && !write_busy_o |=> cpu_stall_o [*2] ##1 !cpu_stall_o;
    endproperty
    a_rd_stall: assert property (p_rd_stall) else $error("read stall length wrong");
    // The synchronised supply flag seen by the design at an edge is the pin sampled two edges earlier
    property p_go; go && arm_cnt != 3'h0 && !$past(low_supply_i, 2) |=>
        cpu_stall_o ##1 (cpu_stall_o && write_busy_o); endproperty
    a_go: assert property (p_go) else $error("armed strobe did not start");
    property p_no_arm; go && arm_cnt == 3'h0 |-> ##2 !write_busy_o; endproperty
    a_no_arm: assert property (p_no_arm) else $error("unarmed strobe started");
    property p_low; go && $past(low_supply_i, 2) |-> ##2 !write_busy_o; endproperty
    a_low: assert property (p_low) else $error("write started at low supply");
    property p_abort; write_busy_o && io_wr_i && (io_addr_i == eac_pkg::DATA_OFFSET ||
        io_addr_i == eac_pkg::ADDR_OFFSET) |-> ##3 !write_busy_o; endproperty
    a_abort: assert property (p_abort) else $error("write not aborted");
    property p_busy_max; busy_cnt <= WRITE_CYCLES + 1; endproperty
    a_busy_max: assert property (p_busy_max) else $error("write never ends");
    c_go: cover property (go && arm_cnt != 3'h0);
    c_read: cover property (ctrl_wr && io_wdata_i == 8'h01);
    c_abort: cover property (write_busy_o && io_wr_i && io_addr_i == eac_pkg::DATA_OFFSET);
endmodule : eac_props
bind eac_top eac_props #(.WRITE_CYCLES(WRITE_CYCLES)) i_eac_props (.core_clk_i, .rst_b_i, .io_addr_i,
    .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o, .cpu_stall_o, .low_supply_i, .write_busy_o);
`default_nettype wire

// file: tb/eac_cpu_model.sv
// Behavioural CPU core performing I/O register accesses
`timescale 1ns/1ps
`default_nettype none
module eac_cpu_model (
    // Clock and stall
    input  wire logic       core_clk_i,
    input  wire logic       cpu_stall_i,
    // I/O register port
    output logic      [5:0] io_addr_o,
    output logic            io_wr_o,
    output logic            io_rd_o,
    output logic      [7:0] io_wdata_o,
    input  wire logic [7:0] io_rdata_i
);
    initial
    begin
        io_addr_o  = 6'h00;
        io_wr_o    = 1'b0;
        io_rd_o    = 1'b0;
        io_wdata_o = 8'h00;
    end
    // A halted core issues nothing until the stall drops
    task automatic start(input logic [5:0] a);
        @(negedge core_clk_i);
        while (cpu_stall_i) @(negedge core_clk_i);
        io_addr_o = a;
    endtask : start
    task automatic io_write(input logic [5:0] a, input logic [7:0] d);
        start(a);
        io_wdata_o = d;
        io_wr_o    = 1'b1;
        @(negedge core_clk_i);
        io_wr_o    = 1'b0;
        io_wdata_o = ~d;
    endtask : io_write
    task automatic io_read(input logic [5:0] a, output logic [7:0] d);
        start(a);
        io_rd_o = 1'b1;
        @(negedge core_clk_i);
        io_rd_o = 1'b0;
        d       = io_rdata_i;
    endtask : io_read
    task automatic wait_idle();
        logic [7:0] s;
        s = 8'h02;
        for (int i = 0; i < 100 && s[1]; i++) io_read(eac_pkg::CTRL_OFFSET, s);
    endtask : wait_idle
    // Gap above 2 lets the arm window lapse before the strobe
    task automatic nv_store(input logic [7:0] a, input logic [7:0] d, input logic arm, input int gap);
        wait_idle();
        io_write(eac_pkg::ADDR_OFFSET, a);
        io_write(eac_pkg::DATA_OFFSET, d);
        if (arm) io_write(eac_pkg::CTRL_OFFSET, 8'h04);
        repeat (gap) @(negedge core_clk_i);
        io_write(eac_pkg::CTRL_OFFSET, 8'h02);
    endtask : nv_store
    task automatic nv_fetch(input logic [7:0] a, output logic [7:0] d);
        wait_idle();
        io_write(eac_pkg::ADDR_OFFSET, a);
        io_write(eac_pkg::CTRL_OFFSET, 8'h01);
        io_read(eac_pkg::DATA_OFFSET, d);
    endtask : nv_fetch
endmodule : eac_cpu_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench of the EEPROM access controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int         WC   = 20;
    localparam logic [5:0] CTRL = eac_pkg::CTRL_OFFSET;
    logic       core_clk_i   = 1'b0;
    logic       rst_b_i      = 1'b0;
    logic       low_supply_i = 1'b0;
    logic [5:0] io_addr_i;
    logic       io_wr_i;
    logic       io_rd_i;
    logic [7:0] io_wdata_i;
    logic [7:0] io_rdata_o;
    logic       cpu_stall_o;
    logic       write_busy_o;
    logic [7:0] v;
    logic [5:0] offs [4] = '{eac_pkg::CTRL_OFFSET, eac_pkg::DATA_OFFSET, eac_pkg::ADDR_OFFSET, 6'h00};
    int         errors  = 0;
    int         checked = 0;
    always #2.5 core_clk_i = ~core_clk_i;
    eac_top #(.WRITE_CYCLES(WC), .DEPTH(256)) i_eac_top (.core_clk_i, .rst_b_i, .io_addr_i, .io_wr_i,
        .io_rd_i, .io_wdata_i, .io_rdata_o, .cpu_stall_o, .low_supply_i, .write_busy_o);
    eac_cpu_model i_eac_cpu_model (.core_clk_i, .cpu_stall_i(cpu_stall_o), .io_addr_o(io_addr_i),
        .io_wr_o(io_wr_i), .io_rd_o(io_rd_i), .io_wdata_o(io_wdata_i), .io_rdata_i(io_rdata_o));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic look(input string what, input logic [5:0] a, input logic [7:0] mask, input logic [7:0] exp);
        i_eac_cpu_model.io_read(a, v);
        chk(what, exp, v & mask);
    endtask : look
    task automatic fetch(input string what, input logic [7:0] a, input logic [7:0] exp);
        i_eac_cpu_model.nv_fetch(a, v);
        chk(what, exp, v);
    endtask : fetch
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (4) @(negedge core_clk_i);
        rst_b_i = 1'b1;
        foreach (offs[i]) look("reset", offs[i], 8'hff, 8'h00);
        $display("test reset done");
        i_eac_cpu_model.nv_store(8'hff, 8'ha5, 1'b1, 0);
        look("strobe", CTRL, 8'hfa, 8'h02);
        repeat (WC - 10) @(negedge core_clk_i);
        look("strobe held", CTRL, 8'hfa, 8'h02);
        fetch("byte 255", 8'hff, 8'ha5);
        look("read strobe", CTRL, 8'hff, 8'h00);
        i_eac_cpu_model.nv_store(8'h00, 8'h5a, 1'b1, 0);
        fetch("byte 0", 8'h00, 8'h5a);
        fetch("byte 255 kept", 8'hff, 8'ha5);
        $display("test write read done");
        i_eac_cpu_model.nv_store(8'h00, 8'h11, 1'b0, 0);
        look("no arm", CTRL, 8'hfa, 8'h00);
        i_eac_cpu_model.nv_store(8'h00, 8'h22, 1'b1, 3);
        look("late arm", CTRL, 8'hfa, 8'h00);
        @(negedge core_clk_i) low_supply_i = 1'b1;
        i_eac_cpu_model.nv_store(8'h00, 8'h33, 1'b1, 0);
        look("low supply", CTRL, 8'hfa, 8'h00);
        @(negedge core_clk_i) low_supply_i = 1'b0;
        fetch("byte 0 kept", 8'h00, 8'h5a);
        $display("test refusal done");
        i_eac_cpu_model.nv_store(8'h00, 8'h44, 1'b1, 0);
        i_eac_cpu_model.io_write(eac_pkg::DATA_OFFSET, 8'h55);
        repeat (3) @(negedge core_clk_i);
        look("abort", CTRL, 8'hfa, 8'h00);
        chk("abort busy", 8'h00, {7'h00, write_busy_o});
        $display("test abort done");
        finish_test();
    end
    // Whole run needs well under a thousand cycles
    initial
    begin
        #20000;
        errors++;
        finish_test();
    end
endmodule : tb
`default_nettype wire
